// *** logic/dshbp_consts.svh ***
`ifndef DSHBP_CONSTS_SVH
`define DSHBP_CONSTS_SVH

// ************************************************
// Widths
// ************************************************
`define DSHBP_ADDR_W 12
`define DSHBP_DATA_W 8
`define DSHBP_PIN_W 24

// ************************************************
// Interrupt polarity control location
// ************************************************
`define DSHBP_INTERRUPT_POLARITY_INVERT_ADDR 12'h006
`define DSHBP_INTERRUPT_POLARITY_INVERT_BIT 4

// ************************************************
// Reset values
// ************************************************
`define DSHBP_PINS_RST 24'h00000e
`define DSHBP_INTERRUPT_POLARITY_INVERT_RST 1'b0
`define DSHBP_RDATA_RST 8'h00
`define DSHBP_OE_N_RST 1'b1
`define DSHBP_ACK_RST 1'b1
`define DSHBP_IRQ_RST 1'b0

`endif

// *** logic/dshbp_pkg.sv ***
package dshbp_pkg;
  // Pin bundle, idle levels at reset: strobes and select high
  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] data;
    logic sel_n;
    logic rd_n;
    logic wr_n;
    logic style;
  } dshbp_pins_t;

  // Core-side access request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dshbp_req_t;

  typedef enum logic [2:0] {
    DSHBP_IDLE   = 3'b001,
    DSHBP_ACCESS = 3'b010,
    DSHBP_DONE   = 3'b100
  } dshbp_state_t;
endpackage

// *** logic/dshbp_port.sv ***
`timescale 1ns/1ps
`include "dshbp_consts.svh"
module dshbp_port #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 8
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic bus_style_select,
  input wire logic [11:0] addr_in,
  input wire logic [7:0] host_data_bus_in,
  output logic [7:0] host_data_bus_out,
  output logic host_data_bus_oe_n,
  input wire logic sel_n,
  input wire logic rd_n,
  input wire logic wr_n,
  output logic transfer_ack_out,
  output logic transfer_ack_oe_n,
  output logic irq_out,
  output dshbp_pkg::dshbp_req_t core_req,
  input wire logic [7:0] core_rdata,
  input wire logic core_done,
  input wire logic core_irq,
  output logic interrupt_polarity_invert
);
  import dshbp_pkg::*;

  // ************************************************
  // Elaboration checks
  // ************************************************
  if (ADDR_W != `DSHBP_ADDR_W || DATA_W != `DSHBP_DATA_W) begin : g_chk
    $error("dshbp_port supports only 12 address and 8 data bits");
  end

  // ************************************************
  // Pin synchronisers
  // ************************************************
  // Three stages; a bit changes only once stages two and three agree,
  // which costs latency but rejects a single metastable sample.
  dshbp_pins_t raw_pins;
  dshbp_pins_t s1_ff;
  dshbp_pins_t s2_ff;
  dshbp_pins_t s3_ff;
  dshbp_pins_t pins_ff;
  dshbp_pins_t nxt_pins;
  logic [`DSHBP_PIN_W-1:0] agree;

  assign raw_pins = '{addr: addr_in, data: host_data_bus_in,
                      sel_n: sel_n, rd_n: rd_n, wr_n: wr_n,
                      style: bus_style_select};
  assign agree = ~(s2_ff ^ s3_ff);
  assign nxt_pins = (s3_ff & agree) | (pins_ff & ~agree);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      s1_ff <= `DSHBP_PINS_RST;
      s2_ff <= `DSHBP_PINS_RST;
      s3_ff <= `DSHBP_PINS_RST;
      pins_ff <= `DSHBP_PINS_RST;
    end else begin
      s1_ff <= raw_pins;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      pins_ff <= nxt_pins;
    end
  end

  // ************************************************
  // Bus style decode
  // ************************************************
  wire m_style = pins_ff.style;
  wire selected = ~pins_ff.sel_n;
  // M-style: write strobe input ignored entirely
  wire i_rd = ~pins_ff.rd_n;
  wire i_wr = ~pins_ff.wr_n & pins_ff.rd_n;
  wire m_rd = pins_ff.rd_n;
  wire want_rd = m_style ? m_rd : i_rd;
  wire want_wr = m_style ? ~m_rd : i_wr;
  wire cycle_on = selected & (m_style | i_rd | i_wr);
  wire start = cycle_on & (want_rd | want_wr);
  // Full 12-bit address passed on; a tied-low top bit is just address zero
  wire [11:0] acc_addr = pins_ff.addr;
  wire interrupt_polarity_invert_hit = acc_addr == `DSHBP_INTERRUPT_POLARITY_INVERT_ADDR;

  // ************************************************
  // Access sequencer
  // ************************************************
  dshbp_state_t state_ff;
  dshbp_state_t nxt_state;
  logic is_rd_ff;
  logic [7:0] rdata_ff;
  dshbp_req_t req_ff;
  dshbp_req_t nxt_req;

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DSHBP_IDLE: begin
        if (start) begin
          nxt_state = DSHBP_ACCESS;
        end
      end
      DSHBP_ACCESS: begin
        if (core_done) begin
          nxt_state = DSHBP_DONE;
        end
      end
      DSHBP_DONE: begin
        // Hold until select goes away, or in I-style the strobe: one access per strobe
        if (!cycle_on) begin
          nxt_state = DSHBP_IDLE;
        end
      end
      default: begin
        nxt_state = DSHBP_IDLE;
      end
    endcase
  end

  wire launch = (state_ff == DSHBP_IDLE) & start;
  wire finish = (state_ff == DSHBP_ACCESS) & core_done;

  // Request is a one-cycle pulse; address and data held from the launch
  assign nxt_req = '{rd: launch & want_rd,
                     wr: launch & want_wr,
                     addr: launch ? acc_addr : req_ff.addr,
                     wdata: launch ? pins_ff.data : req_ff.wdata};

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_ff <= DSHBP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      req_ff <= '0;
    end else begin
      req_ff <= nxt_req;
    end
  end

  // Read data caught once, on the finishing edge; the core may drop it later
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      is_rd_ff <= 1'b0;
      rdata_ff <= `DSHBP_RDATA_RST;
    end else begin
      is_rd_ff <= launch ? want_rd : is_rd_ff;
      rdata_ff <= (finish && is_rd_ff) ? core_rdata : rdata_ff;
    end
  end

  // ************************************************
  // Interrupt polarity control
  // ************************************************
  // Snooped from writes to its location so the port can bend irq itself
  logic interrupt_polarity_invert_ff;
  wire nxt_interrupt_polarity_invert = (launch && want_wr && interrupt_polarity_invert_hit) ?
                  pins_ff.data[`DSHBP_INTERRUPT_POLARITY_INVERT_BIT] : interrupt_polarity_invert_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      interrupt_polarity_invert_ff <= `DSHBP_INTERRUPT_POLARITY_INVERT_RST;
    end else begin
      interrupt_polarity_invert_ff <= nxt_interrupt_polarity_invert;
    end
  end

  // ************************************************
  // Data bus driver
  // ************************************************
  wire in_done = state_ff == DSHBP_DONE;
  wire busy = launch | (state_ff == DSHBP_ACCESS);
  // Enable drops with select even while still done, so no bus fight
  wire nxt_doe_n = ~(in_done & is_rd_ff & selected);

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      host_data_bus_out <= `DSHBP_RDATA_RST;
      host_data_bus_oe_n <= `DSHBP_OE_N_RST;
    end else begin
      host_data_bus_out <= rdata_ff;
      host_data_bus_oe_n <= nxt_doe_n;
    end
  end

  // ************************************************
  // Ready and acknowledge driver
  // ************************************************
  // I-style ready: driven while selected, low until the access ends
  // M-style acknowledge: low in the done phase, floating otherwise
  wire nxt_ack = m_style ? 1'b0 : ~busy;
  wire nxt_ack_oe_n = m_style ? ~(in_done & selected) : ~selected;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      transfer_ack_out <= `DSHBP_ACK_RST;
      transfer_ack_oe_n <= `DSHBP_OE_N_RST;
    end else begin
      transfer_ack_out <= nxt_ack;
      transfer_ack_oe_n <= nxt_ack_oe_n;
    end
  end

  // ************************************************
  // Interrupt driver
  // ************************************************
  // Core irq shares our clock, so it needs no synchroniser
  wire nxt_irq = core_irq ^ m_style ^ interrupt_polarity_invert_ff;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      irq_out <= `DSHBP_IRQ_RST;
    end else begin
      irq_out <= nxt_irq;
    end
  end

  // ************************************************
  // Core side
  // ************************************************
  assign core_req = req_ff;
  assign interrupt_polarity_invert = interrupt_polarity_invert_ff;
endmodule

// *** dv/dshbp_core_model.sv ***
`timescale 1ns/1ps
module dshbp_core_model (
  input wire logic ref_clk,
  input wire dshbp_pkg::dshbp_req_t core_req,
  output logic [7:0] core_rdata,
  output logic core_done
);
  import dshbp_pkg::*;
  logic [7:0] mem [4096];
  // Latency from low address bits: prompt and slow answers
  initial begin
    core_done = 1'b0;
    core_rdata = 8'h00;
    forever begin
      @(posedge ref_clk) #1;
      if (core_req.rd | core_req.wr) begin
        if (core_req.wr) mem[core_req.addr] = core_req.wdata;
        repeat (core_req.addr[1:0]) @(posedge ref_clk) #1;
        core_done = 1'b1;
        core_rdata = mem[core_req.addr];
        @(posedge ref_clk) #1;
        core_done = 1'b0;
        core_rdata = ~core_rdata;
      end
    end
  end
endmodule

// *** dv/dshbp_port_assertions.sv ***
`timescale 1ns/1ps
module dshbp_port_chk (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic bus_style_select,
  input wire logic sel_n,
  input wire logic host_data_bus_oe_n,
  input wire logic transfer_ack_out,
  input wire logic transfer_ack_oe_n,
  input wire logic irq_out,
  input wire dshbp_pkg::dshbp_req_t core_req,
  input wire logic core_irq,
  input wire logic interrupt_polarity_invert
);
  import dshbp_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire req = core_req.rd | core_req.wr;
  wire m = bus_style_select;
  wire ip = interrupt_polarity_invert;
  a_no_sel_req: assert property (sel_n [*8] |=> !req)
    else $error("request without select");
  a_sel_float: assert property (sel_n [*8] |-> host_data_bus_oe_n)
    else $error("bus driven without select");
  a_wr_float: assert property (core_req.wr |-> host_data_bus_oe_n [*8])
    else $error("bus driven in write");
  a_one_req: assert property (
    req |-> !(core_req.rd && core_req.wr) ##1 !req)
    else $error("bad request pulse");
  a_ready_wait: assert property (req && !m |-> !transfer_ack_out [*2])
    else $error("ready high too early");
  a_dtack_wait: assert property (req && m |->
    (transfer_ack_oe_n || transfer_ack_out) [*2]) else $error("early ack");
  a_data_ack: assert property ($fell(host_data_bus_oe_n) |->
    transfer_ack_out == !m) else $error("data without ack");
  a_irq_sense: assert property (
    (!reset && $stable({core_irq, m, ip})) [*8]
    |-> irq_out == (core_irq ^ m ^ ip)) else $error("irq sense");
  a_interrupt_polarity_invert_snoop: assert property (
    core_req.wr && core_req.addr == 12'h006
    |-> ##[0:3] ip == core_req.wdata[4]) else $error("polarity bit");
  cover property (req && m);
  cover property (req && !m);
  cover property ($fell(host_data_bus_oe_n));
  cover property (core_req.wr && core_req.addr == 12'h006);
endmodule
bind dshbp_port dshbp_port_chk u_chk (
  .ref_clk(ref_clk),
  .reset(reset),
  .bus_style_select(bus_style_select),
  .sel_n(sel_n),
  .host_data_bus_oe_n(host_data_bus_oe_n),
  .transfer_ack_out(transfer_ack_out),
  .transfer_ack_oe_n(transfer_ack_oe_n),
  .irq_out(irq_out),
  .core_req(core_req),
  .core_irq(core_irq),
  .interrupt_polarity_invert(interrupt_polarity_invert)
);

// *** dv/test_dual_style_host_bus_port.sv ***
`timescale 1ns/1ps
module test_dual_style_host_bus_port;
  import dshbp_pkg::*;
  logic ref_clk, reset, m, sel_n, rd_n, wr_n, core_irq, core_done;
  logic oe_n, ack, ack_oe_n, irq, ip, ipv;
  logic [11:0] addr, a;
  logic [7:0] hd, bus_out, core_rdata, q, d;
  dshbp_req_t core_req;
  int n_errors = 0, check_count = 0, cyc = 0, seed = 58;
  dshbp_port u_dut (.ref_clk(ref_clk), .reset(reset), .bus_style_select(m),
    .addr_in(addr), .host_data_bus_in(oe_n ? hd : bus_out),
    .host_data_bus_out(bus_out), .host_data_bus_oe_n(oe_n), .sel_n(sel_n),
    .rd_n(rd_n), .wr_n(wr_n), .transfer_ack_out(ack),
    .transfer_ack_oe_n(ack_oe_n), .irq_out(irq), .core_req(core_req),
    .core_rdata(core_rdata), .core_done(core_done), .core_irq(core_irq),
    .interrupt_polarity_invert(ipv));
  dshbp_core_model u_core (.ref_clk(ref_clk), .core_req(core_req),
    .core_rdata(core_rdata), .core_done(core_done));
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) if (++cyc == 20000) begin
    n_errors++;
    finish_test();
  end
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk) #1;
  endtask
  // Strobe held until ready or acknowledge, released then or after 60 cycles at most
  task automatic access(input logic w, input logic [7:0] v);
    int n;
    n = 0;
    addr = a;
    hd = v;
    rd_n = m ^ w;
    wr_n = m | !w;
    sel_n = 1'b0;
    while (!m && ack === 1'b1 && n < 30) begin @(posedge ref_clk) #1 n++; end
    if (!m) check(ack, 1'b0);
    while ((m ? ack_oe_n | ack : !ack) && n < 60) begin
      @(posedge ref_clk) #1 n++;
    end
    check(n < 60, 1'b1);
    check(oe_n, w);
    check(ack_oe_n, 1'b0);
    q = bus_out;
    sel_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    hd = ~v;
    idle(10);
    check(oe_n, 1'b1);
    check(ack_oe_n, 1'b1);
  endtask
  initial begin
    {m, sel_n, rd_n, wr_n, addr, hd} = {4'h7, 20'h0};
    {core_irq, ip, reset} = 3'h1;
    idle(4);
    reset = 1'b0;
    for (int i = 0; i < 40; i++) begin
      a = $random(seed);
      d = $random(seed);
      if (i % 4 == 0) a = 12'h006;
      else if (i[0]) a[11] = 1'b0;
      m = $random(seed);
      core_irq = $random(seed);
      idle(10);
      access(1'b1, d);
      if (a == 12'h006) ip = d[4];
      m = $random(seed);
      idle(10);
      access(1'b0, 8'h00);
      check(q, d);
      check(irq, core_irq ^ m ^ ip);
      check(ipv, ip);
    end
    $display("random access test done");
    finish_test();
  end
endmodule
